// ===== inc/enc_param_map.vh
// constants of the encoder parameter and speed check block
// assumes a 40 MHz system clock
`ifndef ENC_PARAM_MAP_VH
`define ENC_PARAM_MAP_VH
// ************************************************************
// parameter block byte offsets (msb first)
// ************************************************************
`define PB_SAFE_INT_OFS   4'h0
`define PB_STD_INT_OFS    4'h2
`define PB_WINDOW_OFS     4'h4
`define PB_IDLE_OFS       4'h6
`define PB_DIR_OFS        4'h7
`define PB_BYTES          4'h8
// ************************************************************
// defaults and ranges
// ************************************************************
`define SAFE_INT_DEF      16'h0002
`define SAFE_INT_MIN      16'h0001
`define SAFE_INT_MAX      16'h000A
`define STD_INT_DEF       16'h0014
`define STD_INT_MIN       16'h0001
`define STD_INT_MAX       16'h0064
`define WINDOW_DEF        16'h03E8
`define WINDOW_MIN        16'h0032
`define WINDOW_MAX        16'h0FA0
`define IDLE_DEF          8'h01
`define IDLE_MIN          8'h01
`define IDLE_MAX          8'h05
`define DIR_DEF           1'b1
// ************************************************************
// timing: base times in us, cycles at 40 MHz
// ************************************************************
`define CLK_MHZ           40
`define SAFE_BASE_US      50000
`define STD_BASE_US       5000
`define SAFE_BASE_CYC     (`SAFE_BASE_US * `CLK_MHZ)
`define STD_BASE_CYC      (`STD_BASE_US * `CLK_MHZ)
// ************************************************************
// register addresses and interrupt bits
// ************************************************************
`define REG_PARAM0        4'h0
`define REG_PARAM1        4'h1
`define REG_CHECKSUM      4'h2
`define REG_CTRL          4'h3
`define REG_STATUS        4'h4
`define REG_IRQ_STAT      4'h5
`define REG_IRQ_CLR       4'h6
`define REG_IRQ_EN        4'h7
`define REG_SAFE_SPEED    4'h8
`define REG_STD_SPEED     4'h9
`define IRQ_APPLIED       0
`define IRQ_REJECTED      1
`define IRQ_DEVIATION     2
`define IRQ_PRESET_BLOCK  3
`endif

// ===== verilog/speed_window.v
// speed integration over a window of base periods
// assumes a one-cycle base tick and a signed step per cycle
`timescale 1ns/100ps
module speed_window
#(
  parameter CNT_W = 16
)
(
  input  wire             clk,
  input  wire             rst,
  input  wire             base_tick,
  input  wire [15:0]      periods,
  input  wire signed [1:0] step,
  output reg  [CNT_W-1:0] speed_r,
  output reg              done_r
);
  reg  [15:0]      tick_cnt_r;
  reg  [CNT_W-1:0] acc_r;
  wire [CNT_W-1:0] step_ext = {{(CNT_W-2){step[1]}}, step};
  wire             win_end  = base_tick && (tick_cnt_r + 16'h0001 >= periods);

  // ************************************************************
  // accumulate steps, latch at window end
  // ************************************************************
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tick_cnt_r <= 16'h0000;
      acc_r      <= {CNT_W{1'b0}};
      speed_r    <= {CNT_W{1'b0}};
      done_r     <= 1'b0;
    end
    else
    begin
      done_r <= win_end;
      if (win_end)
      begin
        speed_r    <= acc_r + step_ext;
        acc_r      <= {CNT_W{1'b0}};
        tick_cnt_r <= 16'h0000;
      end
      else
      begin
        acc_r <= acc_r + step_ext;
        if (base_tick)
          tick_cnt_r <= tick_cnt_r + 16'h0001;
      end
    end
  end
endmodule // speed_window

// ===== verilog/encoder_param_speed_check.v
// parameter set holder and speed/deviation checker of a dual-scan encoder
// assumes scan step pulses from both scanning units, register port from
// the same clock, step inputs from a foreign domain
//
// The address-and-strobe port and the register offsets were decided locally.
`timescale 1ns/100ps
`include "enc_param_map.vh"
module encoder_param_speed_check
#(
  parameter SAFE_BASE_CYC = `SAFE_BASE_CYC,
  parameter STD_BASE_CYC  = `STD_BASE_CYC,
  parameter POS_W         = 28
)
(
  input  wire              CLK_SYS,
  input  wire              SYS_RST,
  input  wire [3:0]        ADDR,
  input  wire [31:0]       WDATA,
  input  wire              WR,
  input  wire              RD,
  input  wire              MST_STEP,
  input  wire              MST_CW,
  input  wire              SLV_STEP,
  input  wire              SLV_CW,
  input  wire              PRESET_REQ,
  input  wire [POS_W-1:0]  PRESET_VAL,
  output reg  [31:0]       RDATA,
  output reg  [15:0]       SAFE_SPEED,
  output reg  [15:0]       STD_SPEED,
  output reg  [POS_W-1:0]  POSITION,
  output reg               PASSIVATED,
  output reg               PRESET_DONE,
  output reg               PRESET_ERR,
  output reg               IRQ
);
  // ************************************************************
  // state
  // ************************************************************
  reg  [31:0]      stage0_r;
  reg  [31:0]      stage1_r;
  reg  [31:0]      cks_r;
  reg  [15:0]      safe_int_r;
  reg  [15:0]      std_int_r;
  reg  [15:0]      window_r;
  reg  [7:0]       idle_r;
  reg              dir_r;
  reg              cks_ok_r;
  reg              dev_err_r;
  reg  [3:0]       irq_stat_r;
  reg  [3:0]       irq_en_r;
  reg  [3:0]       irq_set;
  reg  [3:0]       sync1_r;
  reg  [3:0]       sync2_r;
  reg  [3:0]       sync3_r;
  reg  [POS_W-1:0] mst_pos_r;
  reg  [POS_W-1:0] slv_pos_r;
  reg  [31:0]      safe_div_r;
  reg  [31:0]      std_div_r;
  reg              safe_tick_r;
  reg              std_tick_r;
  reg  [31:0]      crc_nxt;
  reg  [POS_W-1:0] diff;
  integer          i;
  wire [15:0]      safe_sp;
  wire [15:0]      std_sp;
  wire             safe_done;
  wire             std_done;
  wire             mst_pulse = sync2_r[0] & ~sync3_r[0];
  wire             slv_pulse = sync2_r[2] & ~sync3_r[2];
  wire             mst_cw    = sync2_r[1];
  wire             slv_cw    = sync2_r[3];
  wire             preset_go;
  wire             apply_go  = WR && (ADDR == `REG_CTRL) && WDATA[0];

  // parameter fields unpacked msb first from the staged block
  wire [15:0] n_safe  = stage0_r[31:16];
  wire [15:0] n_std   = stage0_r[15:0];
  wire [15:0] n_win   = stage1_r[31:16];
  wire [7:0]  n_idle  = stage1_r[15:8];
  wire        n_dir   = stage1_r[0];
  wire        in_range =
    (n_safe >= `SAFE_INT_MIN) && (n_safe <= `SAFE_INT_MAX) &&
    (n_std >= `STD_INT_MIN) && (n_std <= `STD_INT_MAX) &&
    (n_win >= `WINDOW_MIN) && (n_win <= `WINDOW_MAX) &&
    (n_idle >= `IDLE_MIN) && (n_idle <= `IDLE_MAX);

  // ************************************************************
  // checksum over the staged block, bitwise crc32 msb first
  // ************************************************************
  wire [63:0] param_blk = {stage0_r, stage1_r}; // block bytes 0..7
  always @*
  begin
    crc_nxt = 32'hFFFF_FFFF;
    for (i = 63; i >= 0; i = i - 1)
    begin
      if (crc_nxt[31] ^ param_blk[i])
        crc_nxt = {crc_nxt[30:0], 1'b0} ^ 32'h04C1_1DB7;
      else
        crc_nxt = {crc_nxt[30:0], 1'b0};
    end
  end
  wire cks_match = (crc_nxt == cks_r);

  // ************************************************************
  // register writes and parameter apply
  // ************************************************************
  always @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      stage0_r   <= 32'h0000_0000;
      stage1_r   <= 32'h0000_0000;
      cks_r      <= 32'h0000_0000;
      safe_int_r <= `SAFE_INT_DEF;
      std_int_r  <= `STD_INT_DEF;
      window_r   <= `WINDOW_DEF;
      idle_r     <= `IDLE_DEF;
      dir_r      <= `DIR_DEF;
      cks_ok_r   <= 1'b0;
      irq_en_r   <= 4'h0;
    end
    else
    begin
      if (WR && ADDR == `REG_PARAM0)
        stage0_r <= WDATA;
      if (WR && ADDR == `REG_PARAM1)
        stage1_r <= WDATA;
      if (WR && ADDR == `REG_CHECKSUM)
        cks_r <= WDATA;
      if (WR && ADDR == `REG_IRQ_EN)
        irq_en_r <= WDATA[3:0];
      if (apply_go)
      begin
        cks_ok_r <= cks_match;
        if (in_range && cks_match)
        begin
          safe_int_r <= n_safe;
          std_int_r  <= n_std;
          window_r   <= n_win;
          idle_r     <= n_idle;
          dir_r      <= n_dir;
        end
      end
    end
  end

  // ************************************************************
  // input synchronisers and base-time dividers
  // ************************************************************
  always @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      sync1_r     <= 4'h0;
      sync2_r     <= 4'h0;
      sync3_r     <= 4'h0;
      safe_div_r  <= 32'h0000_0000;
      std_div_r   <= 32'h0000_0000;
      safe_tick_r <= 1'b0;
      std_tick_r  <= 1'b0;
    end
    else
    begin
      sync1_r     <= {SLV_CW, SLV_STEP, MST_CW, MST_STEP};
      sync2_r     <= sync1_r;
      sync3_r     <= sync2_r;
      safe_tick_r <= (safe_div_r == SAFE_BASE_CYC - 1);
      std_tick_r  <= (std_div_r == STD_BASE_CYC - 1);
      safe_div_r  <= (safe_div_r == SAFE_BASE_CYC - 1) ? 32'h0000_0000
                   : safe_div_r + 32'h0000_0001;
      std_div_r   <= (std_div_r == STD_BASE_CYC - 1) ? 32'h0000_0000
                   : std_div_r + 32'h0000_0001;
    end
  end

  // step sign follows the counting direction
  wire signed [1:0] mst_step = !mst_pulse ? 2'sb00
                             : ((mst_cw == dir_r) ? 2'sb01 : 2'sb11);

  // ************************************************************
  // speed windows: safe (50 ms base) and standard (5 ms base)
  // ************************************************************
  speed_window #(.CNT_W(16)) u_safe_win
  (
    .clk       (CLK_SYS),
    .rst       (SYS_RST),
    .base_tick (safe_tick_r),
    .periods   (safe_int_r),
    .step      (mst_step),
    .speed_r   (safe_sp),
    .done_r    (safe_done)
  );

  speed_window #(.CNT_W(16)) u_std_win
  (
    .clk       (CLK_SYS),
    .rst       (SYS_RST),
    .base_tick (std_tick_r),
    .periods   (std_int_r),
    .step      (mst_step),
    .speed_r   (std_sp),
    .done_r    (std_done)
  );

  // standstill test on the latest safe-window speed
  wire [15:0] safe_mag = safe_sp[15] ? (~safe_sp + 16'h0001) : safe_sp;
  wire        standstill = (safe_mag <= {8'h00, idle_r});
  assign preset_go = PRESET_REQ && !PRESET_DONE && !PRESET_ERR;

  // ************************************************************
  // positions, deviation check, outputs
  // ************************************************************
  always @*
  begin
    diff = (mst_pos_r >= slv_pos_r) ? (mst_pos_r - slv_pos_r)
         : (slv_pos_r - mst_pos_r);
  end

  always @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      mst_pos_r   <= {POS_W{1'b0}};
      slv_pos_r   <= {POS_W{1'b0}};
      dev_err_r   <= 1'b0;
      SAFE_SPEED  <= 16'h0000;
      STD_SPEED   <= 16'h0000;
      POSITION    <= {POS_W{1'b0}};
      PASSIVATED  <= 1'b1;
      PRESET_DONE <= 1'b0;
      PRESET_ERR  <= 1'b0;
    end
    else
    begin
      if (preset_go && standstill)
      begin
        mst_pos_r <= PRESET_VAL;
        slv_pos_r <= PRESET_VAL;
      end
      else
      begin
        if (mst_pulse)
          mst_pos_r <= (mst_cw == dir_r) ? mst_pos_r + 1'b1 : mst_pos_r - 1'b1;
        if (slv_pulse)
          slv_pos_r <= (slv_cw == dir_r) ? slv_pos_r + 1'b1 : slv_pos_r - 1'b1;
      end
      dev_err_r  <= (diff > {{(POS_W-16){1'b0}}, window_r});
      PASSIVATED <= dev_err_r;
      if (dev_err_r)
        SAFE_SPEED <= 16'h0000;
      else if (safe_done)
        SAFE_SPEED <= safe_sp;
      if (std_done)
        STD_SPEED <= std_sp;
      POSITION <= dev_err_r ? {POS_W{1'b0}} : mst_pos_r;
      if (!PRESET_REQ)
      begin
        PRESET_DONE <= 1'b0;
        PRESET_ERR  <= 1'b0;
      end
      else if (preset_go)
      begin
        PRESET_DONE <= standstill;
        PRESET_ERR  <= !standstill;
      end
    end
  end

  // ************************************************************
  // interrupt status: set wins over clear
  // ************************************************************
  always @*
  begin
    irq_set = 4'h0;
    irq_set[`IRQ_APPLIED]      = apply_go && in_range && cks_match;
    irq_set[`IRQ_REJECTED]     = apply_go && !(in_range && cks_match);
    irq_set[`IRQ_DEVIATION]    = dev_err_r;
    irq_set[`IRQ_PRESET_BLOCK] = preset_go && !standstill;
  end

  always @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      irq_stat_r <= 4'h0;
      IRQ        <= 1'b0;
      RDATA      <= 32'h0000_0000;
    end
    else
    begin
      if (WR && ADDR == `REG_IRQ_CLR)
        irq_stat_r <= (irq_stat_r & ~WDATA[3:0]) | irq_set;
      else
        irq_stat_r <= irq_stat_r | irq_set;
      IRQ <= |(irq_stat_r & irq_en_r);
      RDATA <= 32'h0000_0000;
      if (RD)
      begin
        case (ADDR)
          `REG_PARAM0:     RDATA <= {safe_int_r, std_int_r};
          `REG_PARAM1:     RDATA <= {window_r, idle_r, 7'h00, dir_r};
          `REG_CHECKSUM:   RDATA <= cks_r;
          `REG_STATUS:     RDATA <= {28'h000_0000, standstill, PASSIVATED,
                                     dev_err_r, cks_ok_r};
          `REG_IRQ_STAT:   RDATA <= {28'h000_0000, irq_stat_r};
          `REG_IRQ_EN:     RDATA <= {28'h000_0000, irq_en_r};
          `REG_SAFE_SPEED: RDATA <= {16'h0000, SAFE_SPEED};
          `REG_STD_SPEED:  RDATA <= {16'h0000, STD_SPEED};
          default:         RDATA <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule // encoder_param_speed_check

// ===== test/enc_chk_checker.sv
// checker of the parameter and speed check block
// assumes one clock domain, bound to the top module ports
`timescale 1ns/100ps
module enc_chk
#(
  parameter POS_W = 28
)
(
  input wire             CLK_SYS,
  input wire             SYS_RST,
  input wire             RD,
  input wire             MST_STEP,
  input wire             PRESET_REQ,
  input wire [POS_W-1:0] PRESET_VAL,
  input wire [31:0]      RDATA,
  input wire [15:0]      SAFE_SPEED,
  input wire [POS_W-1:0] POSITION,
  input wire             PASSIVATED,
  input wire             PRESET_DONE,
  input wire             PRESET_ERR
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);
  // ************************************************************
  // properties
  // ************************************************************
  sequence s_take;
    PRESET_REQ && !PRESET_DONE && !PRESET_ERR;
  endsequence
  property p_rd_idle; !$past(RD) |-> RDATA == 32'h0000_0000; endproperty
  property p_pre_ans; s_take |=> PRESET_DONE != PRESET_ERR; endproperty
  property p_pre_hold;
    (PRESET_DONE || PRESET_ERR) && PRESET_REQ |=> $stable({PRESET_DONE, PRESET_ERR});
  endproperty
  property p_pre_clr; !PRESET_REQ |=> !PRESET_DONE && !PRESET_ERR; endproperty
  property p_pre_load;
    s_take ##1 PRESET_DONE ##1 !PASSIVATED |-> POSITION == $past(PRESET_VAL, 2);
  endproperty
  property p_pass_rise; $rose(PASSIVATED) |-> SAFE_SPEED == 16'h0000 && POSITION == '0; endproperty
  property p_pass_spd; PASSIVATED ##1 PASSIVATED |-> $past(SAFE_SPEED) == 16'h0000; endproperty
  property p_pass_pos; PASSIVATED ##1 PASSIVATED |-> $past(POSITION) == '0; endproperty
  property p_pos_still;
    (!$changed(MST_STEP) && !PRESET_REQ && !PASSIVATED)[*6] |-> $stable(POSITION);
  endproperty
  a_rd_idle:   assert property (p_rd_idle)   else $error("read data not idle");
  a_pre_ans:   assert property (p_pre_ans)   else $error("preset not answered");
  a_pre_hold:  assert property (p_pre_hold)  else $error("preset answer dropped");
  a_pre_clr:   assert property (p_pre_clr)   else $error("preset answer not cleared");
  a_pre_load:  assert property (p_pre_load)  else $error("preset value not loaded");
  a_pass_rise: assert property (p_pass_rise) else $error("outputs not zero");
  a_pass_spd:  assert property (p_pass_spd)  else $error("safe speed not zero");
  a_pass_pos:  assert property (p_pass_pos)  else $error("position not zero");
  a_pos_still: assert property (p_pos_still) else $error("position moved at rest");
  c_pass: cover property ($rose(PASSIVATED));
  c_done: cover property (s_take ##1 PRESET_DONE);
  c_err:  cover property (s_take ##1 PRESET_ERR);
endmodule // enc_chk
bind encoder_param_speed_check enc_chk #(.POS_W(POS_W)) u_chk
(
  .CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .RD(RD), .MST_STEP(MST_STEP),
  .PRESET_REQ(PRESET_REQ), .PRESET_VAL(PRESET_VAL), .RDATA(RDATA),
  .SAFE_SPEED(SAFE_SPEED), .POSITION(POSITION), .PASSIVATED(PASSIVATED),
  .PRESET_DONE(PRESET_DONE), .PRESET_ERR(PRESET_ERR)
);

// ===== test/enc_host.sv
// host model: register port master that sends parameter sets with checksum
// assumes the same clock as the block
`timescale 1ns/100ps
`include "enc_param_map.vh"
module enc_host
(
  input  wire        clk,
  input  wire [31:0] rdata,
  output reg  [3:0]  addr,
  output reg  [31:0] wdata,
  output reg         wr,
  output reg         rd
);
  // idle bus
  initial
  begin
    addr = 4'h0;
    wdata = 32'h0000_0000;
    wr = 1'b0;
    rd = 1'b0;
  end
  // ************************************************************
  // bus cycles
  // ************************************************************
  task wr_reg(input [3:0] a, input [31:0] dv);
  begin
    @(posedge clk);
    addr <= a;
    wdata <= dv;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  end
  endtask
  // data taken at the edge after the strobe cycle
  task rd_reg(input [3:0] a, output [31:0] dv);
  begin
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    dv = rdata;
  end
  endtask
  // checksum over both words, msb first
  function [31:0] crc(input [63:0] m);
    reg [31:0] c;
    integer i;
  begin
    c = 32'hFFFF_FFFF;
    for (i = 63; i >= 0; i = i - 1)
      c = {c[30:0], 1'b0} ^ ((c[31] ^ m[i]) ? 32'h04C1_1DB7 : 32'h0000_0000);
    crc = c;
  end
  endfunction
  // fresh checksum after every change, optionally spoiled
  task apply(input [31:0] p0, input [31:0] p1, input bad);
  begin
    wr_reg(`REG_PARAM0, p0);
    wr_reg(`REG_PARAM1, p1);
    wr_reg(`REG_CHECKSUM, crc({p0, p1}) ^ {31'h0000_0000, bad});
    wr_reg(`REG_CTRL, 32'h0000_0001);
  end
  endtask
endmodule // enc_host

// ===== test/tb_encoder_param_speed_check.sv
// testbench of the parameter and speed check block
// assumes short base periods of 100 and 10 cycles
`timescale 1ns/100ps
`include "enc_param_map.vh"
module tb_encoder_param_speed_check;
  reg         clk_sys, sys_rst, mst_step, slv_step, preset_req, cw;
  reg  [27:0] preset_val;
  wire [3:0]  addr;
  wire [31:0] wdata, rdata;
  wire        wr, rd, passivated, preset_done, preset_err, irq;
  wire [15:0] safe_speed, std_speed;
  wire [27:0] position;
  reg  [31:0] d;
  reg  [63:0] bad_tab [0:4];
  integer     n_errors, cmp_count, i;
  enc_host u_host (.clk(clk_sys), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
  encoder_param_speed_check #(.SAFE_BASE_CYC(100), .STD_BASE_CYC(10)) u_dut
  (
    .CLK_SYS(clk_sys), .SYS_RST(sys_rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .MST_STEP(mst_step), .MST_CW(cw), .SLV_STEP(slv_step), .SLV_CW(cw),
    .PRESET_REQ(preset_req), .PRESET_VAL(preset_val), .RDATA(rdata),
    .SAFE_SPEED(safe_speed), .STD_SPEED(std_speed), .POSITION(position),
    .PASSIVATED(passivated), .PRESET_DONE(preset_done), .PRESET_ERR(preset_err), .IRQ(irq)
  );
  // ************************************************************
  // helpers
  // ************************************************************
  task check(input string nm, input [31:0] e, input [31:0] s);
  begin
    cmp_count = cmp_count + 1;
    if (s !== e)
    begin
      $display("[ERR] %0s expected %h seen %h", nm, e, s);
      n_errors = n_errors + 1;
    end
  end
  endtask
  task rchk(input [3:0] a, input [31:0] e);
  begin
    u_host.rd_reg(a, d);
    check("register", e, d);
  end
  endtask
  task steps(input integer n, input m, input s);
  begin
    repeat (n)
    begin
      @(posedge clk_sys);
      mst_step <= m;
      slv_step <= s;
      repeat (2) @(posedge clk_sys);
      mst_step <= 1'b0;
      slv_step <= 1'b0;
      @(posedge clk_sys);
    end
    repeat (6) @(posedge clk_sys);
  end
  endtask
  task end_of_test;
  begin
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  end
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  task t_defaults;
  begin
    rchk(`REG_PARAM0, 32'h0002_0014);
    rchk(`REG_PARAM1, 32'h03E8_0101);
    rchk(4'hF, 32'h0000_0000);
    check("passivated", 32'h0, passivated);
    $display("defaults done");
  end
  endtask
  task t_apply;
  begin
    u_host.wr_reg(`REG_IRQ_EN, 32'h0000_000F);
    u_host.apply(32'h0001_0002, 32'h0032_0501, 1'b0);
    rchk(`REG_PARAM0, 32'h0001_0002);
    rchk(`REG_PARAM1, 32'h0032_0501);
    rchk(`REG_STATUS, 32'h0000_0009);
    rchk(`REG_IRQ_STAT, 32'h0000_0001);
    check("irq", 32'h1, irq);
    u_host.wr_reg(`REG_IRQ_CLR, 32'h0000_000F);
    rchk(`REG_IRQ_STAT, 32'h0000_0000);
    check("irq", 32'h0, irq);
    $display("apply done");
  end
  endtask
  task t_reject;
  begin
    for (i = 0; i < 5; i = i + 1)
    begin
      u_host.apply(bad_tab[i][63:32], bad_tab[i][31:0], i == 0);
      rchk(`REG_PARAM0, 32'h0001_0002);
      rchk(`REG_PARAM1, 32'h0032_0501);
      rchk(`REG_IRQ_STAT, 32'h0000_0002);
      rchk(`REG_STATUS, (i == 0) ? 32'h0000_0008 : 32'h0000_0009);
      u_host.wr_reg(`REG_IRQ_CLR, 32'h0000_000F);
    end
    $display("reject done");
  end
  endtask
  task t_speed;
  begin
    fork
      steps(60, 1'b1, 1'b1);
      begin
        repeat (200) @(posedge clk_sys);
        check("safe speed", 32'h1, safe_speed >= 24 && safe_speed <= 26);
        check("std speed", 32'h1, std_speed >= 4 && std_speed <= 6);
        preset_val <= 28'h000_0100;
        preset_req <= 1'b1;
        repeat (2) @(posedge clk_sys);
        check("preset err", 32'h1, preset_err);
        preset_req <= 1'b0;
      end
    join
    check("position", 32'd60, position);
    repeat (250) @(posedge clk_sys);
    preset_req <= 1'b1;
    repeat (2) @(posedge clk_sys);
    check("preset done", 32'h1, preset_done);
    // loaded position reaches the output one cycle after the answer
    @(posedge clk_sys);
    check("position", 32'h0000_0100, position);
    preset_req <= 1'b0;
    rchk(`REG_IRQ_STAT, 32'h0000_0008);
    rchk(`REG_STD_SPEED, 32'h0000_0000);
    u_host.wr_reg(`REG_IRQ_CLR, 32'h0000_000F);
    $display("speed done");
  end
  endtask
  task t_dir_dev;
  begin
    u_host.apply(32'h0001_0002, 32'h0032_0500, 1'b0);
    steps(10, 1'b1, 1'b1);
    check("position", 32'd246, position);
    steps(60, 1'b1, 1'b0);
    check("passivated", 32'h1, passivated);
    check("position", 32'h0, position);
    check("safe speed", 32'h0, safe_speed);
    rchk(`REG_IRQ_STAT, 32'h0000_0005);
    rchk(`REG_SAFE_SPEED, 32'h0000_0000);
    steps(60, 1'b0, 1'b1);
    check("passivated", 32'h0, passivated);
    check("position", 32'd186, position);
    // counter-clockwise turn with decreasing direction counts up
    cw <= 1'b0;
    steps(5, 1'b1, 1'b1);
    check("position", 32'd191, position);
    cw <= 1'b1;
    $display("direction and deviation done");
  end
  endtask
  // ************************************************************
  // clock, reset, sequence, watchdog
  // ************************************************************
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  initial
  begin
    #(25 * 20000);
    n_errors = n_errors + 1;
    end_of_test;
  end
  initial
  begin
    n_errors = 0;
    cmp_count = 0;
    sys_rst = 1'b1;
    mst_step = 1'b0;
    slv_step = 1'b0;
    preset_req = 1'b0;
    cw = 1'b1;
    preset_val = 28'h000_0000;
    bad_tab[0] = {32'h0003_0004, 32'h0032_0501};
    bad_tab[1] = {32'h000B_0002, 32'h0032_0501};
    bad_tab[2] = {32'h0001_0065, 32'h0032_0501};
    bad_tab[3] = {32'h0001_0002, 32'h0FA1_0501};
    bad_tab[4] = {32'h0001_0002, 32'h0032_0601};
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_defaults;
    t_apply;
    t_reject;
    t_speed;
    t_dir_dev;
    end_of_test;
  end
endmodule // tb_encoder_param_speed_check
